//--- verilog/sebl_defines.svh
// constants for the serial boot loader
// assumes inclusion by the loader package and design files only
`ifndef SEBL_DEFINES_SVH
`define SEBL_DEFINES_SVH
`define SEBL_READ_OP   8'h03
`define SEBL_ADDR_BYTE 8'h00
`define SEBL_DUMMY     8'h00
`define SEBL_KEY       16'h08aa
`define SEBL_END_SIZE  16'h0000
`define SEBL_BRR_SLOW  8'h0f
`define SEBL_LSP_SLOW  8'h07
`define SEBL_RSV_LAST  3'h6
`define SEBL_CHAR_LEN  4'h8
`define SEBL_CPHA      1'h1
`define SEBL_CPOL      1'h0
`define SEBL_BIT_LAST  3'h7
`define SEBL_ADDR2_CNT 3'h1
`define SEBL_ADDR3_CNT 3'h2
`endif

//--- verilog/sebl_pkg.sv
// types shared by the serial boot loader
// assumes the defines header sits beside it
package sebl_pkg;
  typedef struct packed {
    logic       master;
    logic       talk;
    logic       fifo_en;
    logic [3:0] char_len;
    logic       phase;
    logic       polarity;
  } sebl_port_cfg_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
  } sebl_wr_t;

  typedef enum logic [12:0] {
    ST_MUX   = 13'h0001,
    ST_INIT  = 13'h0002,
    ST_CMD   = 13'h0004,
    ST_ADDR  = 13'h0008,
    ST_KEY   = 13'h0010,
    ST_CFG   = 13'h0020,
    ST_RSV   = 13'h0040,
    ST_ENTRY = 13'h0080,
    ST_SIZE  = 13'h0100,
    ST_DEST  = 13'h0200,
    ST_DATA  = 13'h0400,
    ST_DONE  = 13'h0800,
    ST_ABORT = 13'h1000
  } sebl_state_t;
endpackage : sebl_pkg

//--- verilog/sebl_loader.sv
// serial memory boot loader: spi master, stream parser, write fifo
// assumes a serial memory behind the pins and a memory write sink
`timescale 1ns/1ns
`include "sebl_defines.svh"

module sebl_fifo #(
  parameter int W  = 48,
  parameter int D  = 8,
  parameter int AW = 3
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          push, pop;

  assign in_ready  = (cnt_ff != (AW+1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rp_ff];

  always_comb begin
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    nxt_wp  = push ? AW'((wp_ff + 1'b1) % D) : wp_ff;
    nxt_rp  = pop ? AW'((rp_ff + 1'b1) % D) : rp_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
    if (push) mem[wp_ff] <= in_data;
  end
endmodule : sebl_fifo

// Operation
// - only an 8-bit byte stream is accepted, never 16-bit words.
// - port set up as master talker, fifo on, 8-bit, phase 1, polarity 0.
// - pins switch to primary function before the port is set up.
// - slave transmit enable line serves as memory chip select.
// - read command byte goes out before any address byte.
// - start address is zero; memory holds image from there.
// - two-byte or three-byte memory addressing both supported.
// - one continuous burst, every transfer exactly eight bits.
// - word is first byte low, second byte high.
// - first word must equal key, else the load aborts.
// - next two bytes set prescaler then bit-rate divider.
// - seven reserved words are read and dropped.
// - entry address read upper half first, top byte zero.
// - blocks copied until size zero, then entry address handed back.
// - block is count, destination high half first, then data words.
module sebl_loader
  import sebl_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic      clk_sys,
  input  wire logic      rst_n,
  input  wire logic      addr_three_byte,
  input  wire logic      serial_master_in_pin,
  output logic           serial_master_out_pin,
  output logic           serial_clock_pin,
  output logic           serial_chip_select_pin,
  output logic           pin_primary,
  output sebl_port_cfg_t port_cfg,
  output logic [7:0]     low_speed_clock_prescaler,
  output logic [7:0]     serial_bit_rate_divider,
  output logic           mem_wr_valid,
  output sebl_wr_t       mem_wr,
  input  wire logic      mem_wr_ready,
  output logic           boot_done,
  output logic           boot_abort,
  output logic [31:0]    entry_point
);
  function automatic logic [16:0] half_period(logic [7:0] brr,
                                              logic [7:0] lsp);
    half_period = 17'(({9'h0, brr} + 17'h1) * ({9'h0, lsp} + 17'h1));
  endfunction : half_period

  // byte shifter state
  logic        busy_ff, nxt_busy, bdone_ff, nxt_bdone;
  logic        sclk_ff, nxt_sclk, mosi_ff, nxt_mosi;
  logic [2:0]  bits_ff, nxt_bits;
  logic [16:0] div_ff, nxt_div;
  logic [7:0]  tx_ff, nxt_tx, rx_ff, nxt_rx;
  logic        go;
  logic [7:0]  go_byte;

  always_comb begin
    nxt_busy  = busy_ff;
    nxt_bdone = 1'b0;
    nxt_sclk  = sclk_ff;
    nxt_mosi  = mosi_ff;
    nxt_bits  = bits_ff;
    nxt_div   = div_ff;
    nxt_tx    = tx_ff;
    nxt_rx    = rx_ff;
    if (!busy_ff) begin
      if (go) begin
        nxt_busy = 1'b1;
        nxt_tx   = go_byte;
        nxt_bits = `SEBL_BIT_LAST;
        nxt_div  = '0;
      end
    end else if (div_ff == 17'(half_period(serial_bit_rate_divider,
                 low_speed_clock_prescaler) - 17'h1)) begin
      nxt_div = '0;
      // phase 1: drive on rise, sample on fall
      if (!sclk_ff) begin
        nxt_sclk = 1'b1;
        nxt_mosi = tx_ff[7];
        nxt_tx   = {tx_ff[6:0], 1'b0};
      end else begin
        nxt_sclk = `SEBL_CPOL;
        nxt_rx   = {rx_ff[6:0], serial_master_in_pin};
        if (bits_ff == '0) begin
          nxt_busy  = 1'b0;
          nxt_bdone = 1'b1;
        end else begin
          nxt_bits = bits_ff - 3'h1;
        end
      end
    end else begin
      nxt_div = div_ff + 17'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy_ff  <= 1'b0;
      bdone_ff <= 1'b0;
      sclk_ff  <= `SEBL_CPOL;
      mosi_ff  <= 1'b0;
      bits_ff  <= '0;
      div_ff   <= '0;
      tx_ff    <= '0;
      rx_ff    <= '0;
    end else begin
      busy_ff  <= nxt_busy;
      bdone_ff <= nxt_bdone;
      sclk_ff  <= nxt_sclk;
      mosi_ff  <= nxt_mosi;
      bits_ff  <= nxt_bits;
      div_ff   <= nxt_div;
      tx_ff    <= nxt_tx;
      rx_ff    <= nxt_rx;
    end
  end

  assign serial_clock_pin      = sclk_ff;
  assign serial_master_out_pin = mosi_ff;

  // stream sequencer state
  sebl_state_t    st_ff, nxt_st;
  sebl_port_cfg_t cfg_ff, nxt_cfg;
  logic        pend_ff, nxt_pend, hi_ff, nxt_hi, a3_ff, nxt_a3;
  logic        cs_n_ff, nxt_cs_n, mux_ff, nxt_mux;
  logic        done_ff, nxt_done, abort_ff, nxt_abort;
  logic [2:0]  cnt_ff, nxt_cnt;
  logic [7:0]  lo_ff, nxt_lo, lsp_ff, nxt_lsp, brr_ff, nxt_brr;
  logic [15:0] blk_ff, nxt_blk, word;
  logic [31:0] dest_ff, nxt_dest, entry_ff, nxt_entry;
  logic [31:0] epo_ff, nxt_epo;
  logic        sending, word_done, push, fifo_in_ready;

  always_comb begin
    sending = (st_ff == ST_CMD) || (st_ff == ST_ADDR) ||
              (st_ff == ST_KEY) || (st_ff == ST_CFG) ||
              (st_ff == ST_RSV) || (st_ff == ST_ENTRY) ||
              (st_ff == ST_SIZE) || (st_ff == ST_DEST) ||
              (st_ff == ST_DATA);
    // stall the burst rather than lose a word when the sink is slow
    go = sending && !busy_ff && !pend_ff &&
         !(st_ff == ST_DATA && !fifo_in_ready);
    // opcode, zero address, then dummy bytes
    go_byte = (st_ff == ST_CMD)  ? `SEBL_READ_OP :
              (st_ff == ST_ADDR) ? `SEBL_ADDR_BYTE : `SEBL_DUMMY;
    nxt_st = st_ff;   nxt_cfg = cfg_ff;  nxt_hi = hi_ff;
    nxt_a3 = a3_ff;   nxt_mux = mux_ff;  nxt_done = done_ff;
    nxt_abort = abort_ff;  nxt_cnt = cnt_ff;  nxt_lo = lo_ff;
    nxt_lsp = lsp_ff; nxt_brr = brr_ff;  nxt_blk = blk_ff;
    nxt_dest = dest_ff;  nxt_entry = entry_ff;  nxt_epo = epo_ff;
    nxt_pend = (pend_ff && !bdone_ff) || go;
    word_done = 1'b0;
    push = 1'b0;
    word = {rx_ff, lo_ff};
    if (bdone_ff && (st_ff != ST_CMD) && (st_ff != ST_ADDR)) begin
      nxt_hi = !hi_ff;
      if (!hi_ff) nxt_lo = rx_ff;
      else word_done = 1'b1;
    end
    case (st_ff)
      ST_MUX: begin
        nxt_mux = 1'b1;
        nxt_st  = ST_INIT;
      end
      ST_INIT: begin
        nxt_cfg = '{1'b1, 1'b1, 1'b1, `SEBL_CHAR_LEN,
                    `SEBL_CPHA, `SEBL_CPOL};
        nxt_lsp = `SEBL_LSP_SLOW;
        nxt_brr = `SEBL_BRR_SLOW;
        nxt_a3  = addr_three_byte;
        nxt_st  = ST_CMD;
      end
      ST_CMD: if (bdone_ff) begin
        nxt_cnt = a3_ff ? `SEBL_ADDR3_CNT : `SEBL_ADDR2_CNT;
        nxt_st  = ST_ADDR;
      end
      ST_ADDR: if (bdone_ff) begin
        if (cnt_ff == '0) begin
          nxt_st = ST_KEY;
          nxt_hi = 1'b0;
        end else nxt_cnt = cnt_ff - 3'h1;
      end
      ST_KEY: if (word_done) nxt_st = (word == `SEBL_KEY) ? ST_CFG
                                                          : ST_ABORT;
      ST_CFG: if (word_done) begin
        nxt_lsp = lo_ff;
        nxt_brr = rx_ff;
        nxt_cnt = '0;
        nxt_st  = ST_RSV;
      end
      ST_RSV: if (word_done) begin
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == `SEBL_RSV_LAST) begin
          nxt_cnt = '0;
          nxt_st  = ST_ENTRY;
        end
      end
      ST_ENTRY: if (word_done) begin
        if (cnt_ff == '0) begin
          nxt_entry[31:16] = word;
          nxt_cnt = 3'h1;
        end else begin
          nxt_entry[15:0] = word;
          nxt_st = ST_SIZE;
        end
      end
      ST_SIZE: if (word_done) begin
        nxt_cnt = '0;
        nxt_blk = word;
        nxt_st  = (word == `SEBL_END_SIZE) ? ST_DONE : ST_DEST;
      end
      ST_DEST: if (word_done) begin
        if (cnt_ff == '0) begin
          nxt_dest[31:16] = word;
          nxt_cnt = 3'h1;
        end else begin
          nxt_dest[15:0] = word;
          nxt_st = ST_DATA;
        end
      end
      ST_DATA: if (word_done) begin
        push     = 1'b1;
        nxt_dest = dest_ff + 32'h1;
        nxt_blk  = blk_ff - 16'h1;
        if (blk_ff == 16'h1) nxt_st = ST_SIZE;
      end
      ST_DONE: begin
        nxt_done = 1'b1;
        nxt_epo  = entry_ff;
      end
      ST_ABORT: nxt_abort = 1'b1;
      default: nxt_st = ST_ABORT;
    endcase
    // select held for the whole burst
    nxt_cs_n = !((nxt_st == ST_CMD) || (nxt_st == ST_ADDR) ||
                 (nxt_st == ST_KEY) || (nxt_st == ST_CFG) ||
                 (nxt_st == ST_RSV) || (nxt_st == ST_ENTRY) ||
                 (nxt_st == ST_SIZE) || (nxt_st == ST_DEST) ||
                 (nxt_st == ST_DATA));
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= ST_MUX;  cfg_ff <= '0;  pend_ff <= 1'b0;
      hi_ff <= 1'b0;    a3_ff <= 1'b0; cs_n_ff <= 1'b1;
      mux_ff <= 1'b0;   done_ff <= 1'b0;  abort_ff <= 1'b0;
      cnt_ff <= '0;     lo_ff <= '0;
      lsp_ff <= `SEBL_LSP_SLOW;  brr_ff <= `SEBL_BRR_SLOW;
      blk_ff <= '0;  dest_ff <= '0;  entry_ff <= '0;  epo_ff <= '0;
    end else begin
      st_ff <= nxt_st;  cfg_ff <= nxt_cfg;  pend_ff <= nxt_pend;
      hi_ff <= nxt_hi;  a3_ff <= nxt_a3;    cs_n_ff <= nxt_cs_n;
      mux_ff <= nxt_mux;  done_ff <= nxt_done;  abort_ff <= nxt_abort;
      cnt_ff <= nxt_cnt;  lo_ff <= nxt_lo;
      lsp_ff <= nxt_lsp;  brr_ff <= nxt_brr;
      blk_ff <= nxt_blk;  dest_ff <= nxt_dest;
      entry_ff <= nxt_entry;  epo_ff <= nxt_epo;
    end
  end

  assign serial_chip_select_pin    = cs_n_ff;
  assign pin_primary               = mux_ff;
  assign port_cfg                  = cfg_ff;
  assign low_speed_clock_prescaler = lsp_ff;
  assign serial_bit_rate_divider   = brr_ff;
  assign boot_done                 = done_ff;
  assign boot_abort                = abort_ff;
  assign entry_point               = epo_ff;

  // write path: fifo then a register stage so outputs are flopped
  sebl_wr_t fifo_out;
  logic     fifo_out_valid, pop, ov_ff, nxt_ov;
  sebl_wr_t ow_ff, nxt_ow;

  sebl_fifo #(.W($bits(sebl_wr_t)), .D(FIFO_DEPTH),
              .AW($clog2(FIFO_DEPTH))) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({dest_ff, word}),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out)
  );

  always_comb begin
    pop    = fifo_out_valid && (!ov_ff || mem_wr_ready);
    nxt_ov = pop || (ov_ff && !mem_wr_ready);
    nxt_ow = pop ? fifo_out : ow_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ov_ff <= 1'b0;
      ow_ff <= '0;
    end else begin
      ov_ff <= nxt_ov;
      ow_ff <= nxt_ow;
    end
  end

  assign mem_wr_valid = ov_ff;
  assign mem_wr       = ow_ff;

  // helper: rising clock edges seen in the current byte
  logic [3:0] edges_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || go) edges_ff <= '0;
    else if (!sclk_ff && nxt_sclk) edges_ff <= edges_ff + 4'h1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_cfg_mode;
    !cs_n_ff |-> cfg_ff.phase && !cfg_ff.polarity && cfg_ff.master
                 && cfg_ff.char_len == `SEBL_CHAR_LEN;
  endproperty
  a_cfg_mode: assert property (p_cfg_mode)
    else $error("port mode wrong while selected");
  property p_mux_first;
    $rose(cfg_ff.master) |-> $past(mux_ff);
  endproperty
  a_mux_first: assert property (p_mux_first)
    else $error("port set up before pin mux");
  property p_cmd_first;
    $fell(cs_n_ff) |-> st_ff == ST_CMD && go
                       && go_byte == `SEBL_READ_OP;
  endproperty
  a_cmd_first: assert property (p_cmd_first)
    else $error("first byte after select not read command");
  property p_addr_zero;
    go && st_ff == ST_ADDR |-> go_byte == `SEBL_ADDR_BYTE;
  endproperty
  a_addr_zero: assert property (p_addr_zero)
    else $error("nonzero address byte");
  property p_eight_bits;
    bdone_ff |-> edges_ff == 4'h8;
  endproperty
  a_eight_bits: assert property (p_eight_bits)
    else $error("byte not eight clocks");
  property p_key_abort;
    word_done && st_ff == ST_KEY && word != `SEBL_KEY
      |=> st_ff == ST_ABORT ##1 boot_abort && cs_n_ff;
  endproperty
  a_key_abort: assert property (p_key_abort)
    else $error("bad key did not abort");
  property p_rates;
    word_done && st_ff == ST_CFG
      |=> lsp_ff == $past(lo_ff) && brr_ff == $past(rx_ff);
  endproperty
  a_rates: assert property (p_rates)
    else $error("rate bytes not applied");
  property p_rsv_seven;
    word_done && st_ff == ST_RSV && cnt_ff == `SEBL_RSV_LAST
      |=> st_ff == ST_ENTRY;
  endproperty
  a_rsv_seven: assert property (p_rsv_seven)
    else $error("reserved count wrong");
  property p_end;
    word_done && st_ff == ST_SIZE && word == `SEBL_END_SIZE
      |=> ##1 boot_done && entry_point == entry_ff;
  endproperty
  a_end: assert property (p_end)
    else $error("end of stream not handled");
  property p_cs_hold;
    !cs_n_ff |=> !cs_n_ff || st_ff == ST_DONE || st_ff == ST_ABORT;
  endproperty
  a_cs_hold: assert property (p_cs_hold)
    else $error("chip select dropped mid burst");
  property p_dummy;
    go && st_ff == ST_DATA |-> go_byte == `SEBL_DUMMY;
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("data byte not dummy");

  c_done:  cover property (boot_done);
  c_abort: cover property (boot_abort);
  c_full:  cover property (!fifo_in_ready);
  c_a3:    cover property (a3_ff && st_ff == ST_KEY);
endmodule : sebl_loader

//--- testbench/sebl_mem_model.sv
// behavioural serial memory answering one burst read per select
// assumes data out on rising and sampled on falling serial clock
`timescale 1ns/1ns
module sebl_mem_model #(
  parameter int IMG_N = 128
) (
  input  wire logic clk_sys,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic three_byte,
  output logic      miso,
  output int        frames,
  output int        rd_cnt,
  output int        bad_cnt
);
  logic [7:0] img [0:IMG_N-1];
  logic [7:0] cur;
  logic [7:0] sh;
  int         bit_n;
  int         byte_n;
  int         hdr;
  initial begin
    miso = 1'b0;
    cur = 8'h5a;
    frames = 0;
    rd_cnt = 0;
    bad_cnt = 0;
    bit_n = 0;
  end
  always @(negedge cs_n) begin
    bit_n = 0;
    byte_n = 0;
    rd_cnt = 0;
    hdr = three_byte ? 4 : 3;
    frames = frames + 1;
  end
  always @(posedge cs_n) if (bit_n != 0) bad_cnt = bad_cnt + 1;
  always @(posedge sclk) if (!cs_n) begin
    if (bit_n == 0) cur = (byte_n >= hdr) ? img[byte_n - hdr] : ~cur;
    miso = cur[7 - bit_n];
  end
  always @(negedge sclk) if (!cs_n) begin
    sh = {sh[6:0], mosi};
    bit_n = bit_n + 1;
    if (bit_n == 8) begin
      if (sh !== ((byte_n == 0) ? 8'h03 : 8'h00)) bad_cnt = bad_cnt + 1;
      if (byte_n >= hdr) rd_cnt = rd_cnt + 1;
      bit_n = 0;
      byte_n = byte_n + 1;
    end
  end
  // released line must not look stable
  always @(posedge clk_sys) if (cs_n) miso = ~miso;
endmodule : sebl_mem_model

//--- testbench/sebl_tb.sv
// self-checking bench for the serial boot loader
// assumes the memory model and design files are compiled first
`timescale 1ns/1ns
module testbench;
  import sebl_pkg::*;
  // slow boot bytes dominate: about 2k cycles each
  localparam int LIMIT = 60000;
  logic           clk_sys = 1'b0;
  logic           rst_n = 1'b0;
  logic           addr_three_byte = 1'b0;
  logic           miso;
  logic           mosi;
  logic           sclk;
  logic           cs_n;
  logic           pin_primary;
  sebl_port_cfg_t port_cfg;
  logic [7:0]     lsp;
  logic [7:0]     brr;
  logic           mem_wr_valid;
  sebl_wr_t       mem_wr;
  logic           mem_wr_ready = 1'b0;
  logic           boot_done;
  logic           boot_abort;
  logic [31:0]    entry_point;
  int             frames;
  int             rd_cnt;
  int             bad_cnt;
  int             num_errors = 0;
  int             total_checks = 0;
  int             cyc = 0;
  int             n;
  logic           stall = 1'b1;
  logic [7:0]     img_q[$];
  logic [47:0]    exp_q[$];
  logic [31:0]    exp_entry;

  always #5 clk_sys = ~clk_sys;

  sebl_loader dut_u (
    .clk_sys                   (clk_sys),
    .rst_n                     (rst_n),
    .addr_three_byte           (addr_three_byte),
    .serial_master_in_pin      (miso),
    .serial_master_out_pin     (mosi),
    .serial_clock_pin          (sclk),
    .serial_chip_select_pin    (cs_n),
    .pin_primary               (pin_primary),
    .port_cfg                  (port_cfg),
    .low_speed_clock_prescaler (lsp),
    .serial_bit_rate_divider   (brr),
    .mem_wr_valid              (mem_wr_valid),
    .mem_wr                    (mem_wr),
    .mem_wr_ready              (mem_wr_ready),
    .boot_done                 (boot_done),
    .boot_abort                (boot_abort),
    .entry_point               (entry_point)
  );

  sebl_mem_model mem_u (
    .clk_sys    (clk_sys),
    .cs_n       (cs_n),
    .sclk       (sclk),
    .mosi       (mosi),
    .three_byte (addr_three_byte),
    .miso       (miso),
    .frames     (frames),
    .rd_cnt     (rd_cnt),
    .bad_cnt    (bad_cnt)
  );

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic put_w(input logic [15:0] w);
    img_q.push_back(w[7:0]);
    img_q.push_back(w[15:8]);
  endtask : put_w

  task automatic build(input logic good);
    logic [31:0] dest;
    logic [15:0] w;
    img_q.delete();
    exp_q.delete();
    put_w(good ? 16'h08aa : 16'h08ab);
    put_w(16'h0100);
    repeat (7) put_w(16'($urandom));
    exp_entry = {8'h00, 24'($urandom)};
    put_w(exp_entry[31:16]);
    put_w(exp_entry[15:0]);
    // second block outgrows the fifo
    for (int b = 3; b <= 12; b += 9) begin
      dest = $urandom & 32'h00ff_fff0;
      put_w(16'(b));
      put_w(dest[31:16]);
      put_w(dest[15:0]);
      for (int i = 0; i < b; i++) begin
        w = 16'($urandom);
        put_w(w);
        exp_q.push_back({dest + 32'(i), w});
      end
    end
    put_w(16'h0000);
    if (!good) exp_q.delete();
    foreach (img_q[i]) mem_u.img[i] = img_q[i];
  endtask : build

  task automatic do_reset(input logic three);
    rst_n = 1'b0;
    addr_three_byte = three;
    repeat (2) @(negedge clk_sys);
    check(cs_n, 1'b1);
    check(pin_primary, 1'b0);
    check({lsp, brr}, 16'h070f);
    check({boot_done, boot_abort, mem_wr_valid}, 3'h0);
    rst_n = 1'b1;
    @(negedge clk_sys);
    check(pin_primary, 1'b1);
    check(64'(port_cfg), 64'h0);
    check(cs_n, 1'b1);
    @(negedge clk_sys);
    check(64'(port_cfg), 64'(9'h1e2));
    check(cs_n, 1'b0);
  endtask : do_reset

  always @(negedge clk_sys) mem_wr_ready <= stall ? 1'b0 : ($urandom % 4 != 0);

  always @(posedge clk_sys)
    if (rst_n && mem_wr_valid === 1'b1 && mem_wr_ready)
      check(64'(mem_wr), exp_q.size() ? 64'(exp_q.pop_front()) : '1);

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      $display("unexpected timeout at %0t: got %h limit %h", $time, cyc, LIMIT);
      wrap_up();
    end
  end

  initial begin
    void'($urandom(20));
    build(1'b1);
    do_reset(1'b1);
    while (mem_wr_valid !== 1'b1) @(negedge clk_sys);
    // sink held off until the fifo refuses
    repeat (1500) @(negedge clk_sys);
    n = rd_cnt;
    repeat (200) @(negedge clk_sys);
    check(64'(rd_cnt), 64'(n));
    check({sclk, cs_n}, 2'b00);
    stall <= 1'b0;
    while (boot_done !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    check(entry_point, exp_entry);
    check({lsp, brr}, 16'h0001);
    check({cs_n, boot_abort}, 2'b10);
    check(64'(rd_cnt), 64'(img_q.size()));
    check(64'(frames), 64'd1);
    while (exp_q.size() != 0) @(negedge clk_sys);
    check(64'(bad_cnt), 64'd0);
    $display("test good load with stall done");
    build(1'b0);
    do_reset(1'b0);
    while (boot_abort !== 1'b1) @(negedge clk_sys);
    repeat (300) @(negedge clk_sys);
    check(64'(rd_cnt), 64'd2);
    check({cs_n, sclk, boot_done}, 3'b100);
    check({lsp, brr}, 16'h070f);
    check(64'(frames), 64'd2);
    check(64'(bad_cnt), 64'd0);
    $display("test key mismatch abort done");
    wrap_up();
  end
endmodule : testbench
